// file: core/smrc_defs.svh
// Constants for the sensor monitor readout core.
// Assumes inclusion from the package and the core module only.
`ifndef SMRC_DEFS_SVH
`define SMRC_DEFS_SVH
// Strap address table, first resistor counts down, second counts up
`define SMRC_ADDR_R1_BASE 7'h1f
`define SMRC_ADDR_R2_BASE 7'h18
`define SMRC_FIFO_DEPTH 16
`define SMRC_FIFO_AW 4
`define SMRC_ACC_SAMPLES 5'h10
// Output format codes
`define SMRC_FMT_RAW 2'h0
`define SMRC_FMT_CHID 2'h1
`define SMRC_FMT_CHID_VALID 2'h2
// Fill mode codes
`define SMRC_FILL_STOP_FULL 2'h0
`define SMRC_FILL_WRAP 2'h1
`define SMRC_FILL_PRE_ALERT 2'h2
`define SMRC_FILL_POST_ALERT 2'h3
// Operating mode codes
`define SMRC_MODE_MANUAL 2'h0
`define SMRC_MODE_AUTO_THRESH 2'h1
`define SMRC_MODE_AUTO_DIAG 2'h2
`define SMRC_MODE_HIGH_PREC 2'h3
`endif

// file: core/smrc_pkg.sv
// Types shared by the sensor monitor readout core.
// Assumes smrc_defs.svh is on the include path.
`include "smrc_defs.svh"
package smrc_pkg;
  // One conversion result from the analog front end
  typedef struct packed {
    logic ch;
    logic [11:0] code;
  } smrc_sample_s;
  // Per-channel window settings
  typedef struct packed {
    logic [11:0] low;
    logic [11:0] high;
    logic [11:0] hyst;
  } smrc_window_s;
  // Host-side read port request
  typedef struct packed {
    logic frame;
    logic byte_done;
  } smrc_rd_s;
endpackage : smrc_pkg

// file: core/smrc_fifo.sv
// Generic valid/ready FIFO used as the result buffer.
// Assumes one clock and a synchronous active-low reset.
module smrc_fifo
  import smrc_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } smrc_fifo_st_s;
  smrc_fifo_st_s st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes; full stalls the source honestly
  assign in_ready = (st.cnt != DEPTH[AW:0]);
  assign out_valid = (st.cnt != '0);
  assign out_data = mem[st.rp];
  assign count = st.cnt;
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  // Pointer update
  always_comb
  begin
    next_st = st;
    if (flush)
    begin
      next_st = '0;
    end
    else
    begin
      if (push)
        next_st.wp = st.wp + 1'b1;
      if (pop)
        next_st.rp = st.rp + 1'b1;
      next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  // Storage, no reset needed since count gates reads
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[st.wp] <= in_data;
  end
endmodule : smrc_fifo

// file: core/smrc_core.sv
// Digital back end of a dual-channel sensor monitor.
// Assumes conversion results arrive as one-cycle strobes and that an I2C
// slave front end holds a read frame as a level and reports finished bytes as pulses.
`include "smrc_defs.svh"
module smrc_core
  import smrc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Oscillator and pacing
  input wire logic osc_lp_tick,
  input wire logic osc_hs_tick,
  input wire logic oscillator_choice,
  input wire logic [7:0] clocks_per_conversion,
  // Strap and address reprogram
  input wire logic [2:0] addr_strap,
  input wire logic addr_reprogram,
  // Sequence control
  input wire logic [1:0] op_mode,
  input wire logic [1:0] scan_channel_enables,
  input wire logic scan_launch_bit,
  input wire logic scan_abort_bit,
  input wire logic [1:0] fifo_fill_mode,
  input wire logic [1:0] out_format,
  // Conversion results
  input wire logic sample_valid,
  input wire smrc_sample_s sample,
  // Window comparator settings
  input wire smrc_window_s window_ch0,
  input wire smrc_window_s window_ch1,
  input wire logic [3:0] alert_debounce_limit,
  input wire logic [1:0] flag_high_clear,
  input wire logic [1:0] flag_low_clear,
  // Host read side
  input wire smrc_rd_s host_rd,
  // Status and outputs
  output logic convert_start,
  output logic convert_ch,
  output logic [6:0] slave_addr,
  output logic busy,
  output logic [15:0] read_word,
  output logic [4:0] fifo_fill,
  output logic [15:0] acc_ch0,
  output logic [15:0] acc_ch1,
  output logic [4:0] acc_count,
  output logic [1:0] flag_high,
  output logic [1:0] flag_low,
  output logic alert
);
  typedef enum logic [1:0] {SMRC_IDLE, SMRC_RUN, SMRC_DONE} smrc_seq_e;

  // Whole module state
  typedef struct packed {
    smrc_seq_e seq;
    logic run;
    logic strap_taken;
    logic [6:0] addr;
    logic [7:0] clk_cnt;
    logic cur_ch;
    logic conv, convch, half;
    logic [15:0] word;
    logic [4:0] entries;
    logic [15:0] acc0, acc1;
    logic [4:0] acc_n;
    logic [1:0] hi_cmp, lo_cmp;
    logic [3:0] ev_cnt0, ev_cnt1;
    logic [1:0] fh, fl;
    logic alert, triggered;
  } smrc_state_s;
  smrc_state_s st, next_st;

  // Buffer links
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop, fifo_flush;
  logic [15:0] fifo_in_data, fifo_out_data;
  logic [4:0] fifo_cnt;
  logic osc_tick, launch, autonomous, gate_ok;
  smrc_window_s win;
  logic [11:0] code;

  //////////////////////////////////////////////////////////////////////////
  // Strap decode, used for the first capture and on reprogram
  function automatic logic [6:0] smrc_strap_addr(input logic [2:0] s);
    if (!s[2])
      return `SMRC_ADDR_R1_BASE - {5'h0, s[1:0]};
    else
      return `SMRC_ADDR_R2_BASE + {5'h0, s[1:0]};
  endfunction : smrc_strap_addr

  // Entry formatting; 12-bit code left-justified, low nibble carries tags
  function automatic logic [15:0] smrc_fmt(input logic [1:0] f, input logic ch,
                                           input logic [11:0] c);
    if (f == `SMRC_FMT_CHID)
      return {c, 3'h0, ch};
    else if (f == `SMRC_FMT_CHID_VALID)
      return {c, 2'h0, ch, 1'b1};
    else
      return {c, 4'h0};
  endfunction : smrc_fmt

  assign osc_tick = oscillator_choice ? osc_lp_tick : osc_hs_tick;
  assign launch = scan_launch_bit;
  assign autonomous = (op_mode == `SMRC_MODE_AUTO_THRESH) ||
                      (op_mode == `SMRC_MODE_AUTO_DIAG);
  assign win = sample.ch ? window_ch1 : window_ch0;
  assign code = sample.code;
  // Fill gating: post-alert mode waits for an alert in autonomous modes
  assign gate_ok = !autonomous ||
                   (fifo_fill_mode != `SMRC_FILL_POST_ALERT) ||
                   st.triggered;
  assign fifo_flush = launch || !resetn;
  assign fifo_in_valid = sample_valid && st.seq == SMRC_RUN && autonomous
                         && gate_ok;
  assign fifo_in_data = smrc_fmt(out_format, sample.ch, code);
  // Word taken on second byte of a frame, only when not running
  assign fifo_pop = host_rd.frame && host_rd.byte_done && st.half &&
                    st.seq != SMRC_RUN && fifo_out_valid;

  smrc_fifo #(
    .WIDTH(16),
    .DEPTH(`SMRC_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .count(fifo_cnt)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole core
  always_comb
  begin
    next_st = st;
    next_st.conv = 1'b0;
    // Strap caught one cycle after release, never inside reset
    if (!st.strap_taken || addr_reprogram)
    begin
      next_st.addr = smrc_strap_addr(addr_strap);
      next_st.strap_taken = 1'b1;
    end
    // Sequencer
    case (st.seq)
      SMRC_IDLE, SMRC_DONE:
      begin
        if (launch && |scan_channel_enables)
        begin
          next_st.seq = SMRC_RUN;
          next_st.clk_cnt = '0;
          next_st.cur_ch = !scan_channel_enables[0];
        end
      end
      SMRC_RUN:
      begin
        if (scan_abort_bit)
          next_st.seq = SMRC_DONE;
        else if (osc_tick)
        begin
          // One conversion per programmed count; channels alternate when both are enabled
          if (st.clk_cnt == '0)
          begin
            next_st.conv = 1'b1;
            next_st.convch = st.cur_ch;
            if (&scan_channel_enables)
              next_st.cur_ch = !st.cur_ch;
          end
          if (st.clk_cnt + 8'h01 >= clocks_per_conversion)
            next_st.clk_cnt = '0;
          else
            next_st.clk_cnt = st.clk_cnt + 8'h01;
        end
        // Done when buffer full (any fill mode but wrap) or accumulation complete
        if ((autonomous && !fifo_in_ready &&
             fifo_fill_mode != `SMRC_FILL_WRAP) ||
            (op_mode == `SMRC_MODE_HIGH_PREC &&
             st.acc_n == `SMRC_ACC_SAMPLES))
          next_st.seq = SMRC_DONE;
      end
      default:
        next_st.seq = SMRC_IDLE;
    endcase
    // Accumulators
    if (launch)
    begin
      next_st.acc0 = '0;
      next_st.acc1 = '0;
      next_st.acc_n = '0;
      next_st.triggered = 1'b0;
    end
    else if (sample_valid && st.seq == SMRC_RUN &&
             op_mode == `SMRC_MODE_HIGH_PREC &&
             st.acc_n != `SMRC_ACC_SAMPLES)
    begin
      if (!sample.ch && scan_channel_enables[0])
        next_st.acc0 = st.acc0 + {4'h0, code};
      if (sample.ch && scan_channel_enables[1])
        next_st.acc1 = st.acc1 + {4'h0, code};
      if (sample.ch || !scan_channel_enables[1])
        next_st.acc_n = st.acc_n + 5'h01;
    end
    // Window comparators with hysteresis on each side
    if (sample_valid)
    begin
      if (code > win.high)
        next_st.hi_cmp[sample.ch] = 1'b1;
      else if (code < win.high - win.hyst)
        next_st.hi_cmp[sample.ch] = 1'b0;
      if (code < win.low)
        next_st.lo_cmp[sample.ch] = 1'b1;
      else if (code > win.low + win.hyst)
        next_st.lo_cmp[sample.ch] = 1'b0;
    end
    // Clear by writing one first, so that a same-cycle set still wins
    next_st.fh = st.fh & ~flag_high_clear;
    next_st.fl = st.fl & ~flag_low_clear;
    // Debounce counters, one per channel, shared limit
    if (sample_valid && !sample.ch)
    begin
      if (!(next_st.hi_cmp[0] || next_st.lo_cmp[0]))
        next_st.ev_cnt0 = '0;
      else if (st.ev_cnt0 >= alert_debounce_limit)
      begin
        next_st.fh[0] = next_st.fh[0] | next_st.hi_cmp[0];
        next_st.fl[0] = next_st.fl[0] | next_st.lo_cmp[0];
      end
      else
        next_st.ev_cnt0 = st.ev_cnt0 + 4'h1;
    end
    if (sample_valid && sample.ch)
    begin
      if (!(next_st.hi_cmp[1] || next_st.lo_cmp[1]))
        next_st.ev_cnt1 = '0;
      else if (st.ev_cnt1 >= alert_debounce_limit)
      begin
        next_st.fh[1] = next_st.fh[1] | next_st.hi_cmp[1];
        next_st.fl[1] = next_st.fl[1] | next_st.lo_cmp[1];
      end
      else
        next_st.ev_cnt1 = st.ev_cnt1 + 4'h1;
    end
    next_st.alert = |(next_st.fh | next_st.fl);
    if (next_st.alert)
      next_st.triggered = 1'b1;
    // Read side: byte pairing and output word
    if (!host_rd.frame)
      next_st.half = 1'b0;
    else if (host_rd.byte_done)
      next_st.half = !st.half;
    if (st.seq == SMRC_RUN || !fifo_out_valid)
      next_st.word = '0;
    else
      next_st.word = fifo_out_data;
    next_st.entries = fifo_cnt;
    next_st.run = (next_st.seq == SMRC_RUN);
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  // Outputs straight from state
  assign convert_start = st.conv;
  assign convert_ch = st.convch;
  assign slave_addr = st.addr;
  assign busy = st.run;
  assign read_word = st.word;
  assign fifo_fill = st.entries;
  assign acc_ch0 = st.acc0;
  assign acc_ch1 = st.acc1;
  assign acc_count = st.acc_n;
  assign flag_high = st.fh;
  assign flag_low = st.fl;
  assign alert = st.alert;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_osc_pick;
    @(posedge ref_clk) disable iff (!resetn)
    (st.seq == SMRC_RUN && !scan_abort_bit && st.clk_cnt == '0 &&
     osc_tick) |=> convert_start;
  endproperty
  a_osc_pick: assert property (p_osc_pick)
    else $error("conversion not started on oscillator tick");
  property p_addr;
    @(posedge ref_clk) disable iff (!resetn)
    $rose(st.strap_taken) |-> slave_addr == smrc_strap_addr($past(addr_strap));
  endproperty
  a_addr: assert property (p_addr)
    else $error("strap address decoded wrongly");
  property p_abort;
    @(posedge ref_clk) disable iff (!resetn)
    (busy && scan_abort_bit) |=> !busy;
  endproperty
  a_abort: assert property (p_abort)
    else $error("busy stayed high after abort");
  property p_busy_zero;
    @(posedge ref_clk) disable iff (!resetn)
    busy |=> read_word == '0;
  endproperty
  a_busy_zero: assert property (p_busy_zero)
    else $error("nonzero data during sequence");
  property p_flush;
    @(posedge ref_clk) disable iff (!resetn)
    scan_launch_bit |=> ##1 fifo_fill == '0;
  endproperty
  a_flush: assert property (p_flush)
    else $error("buffer not cleared on launch");
  property p_acc_clr;
    @(posedge ref_clk) disable iff (!resetn)
    scan_launch_bit |=> acc_ch0 == '0 && acc_ch1 == '0 && acc_count == '0;
  endproperty
  a_acc_clr: assert property (p_acc_clr)
    else $error("accumulators not cleared on launch");
  property p_fill_max;
    @(posedge ref_clk) disable iff (!resetn)
    fifo_fill <= 5'h10;
  endproperty
  a_fill_max: assert property (p_fill_max)
    else $error("buffer count above depth");
  property p_alert;
    @(posedge ref_clk) disable iff (!resetn)
    $changed(flag_high | flag_low) |-> alert == |(flag_high | flag_low);
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert not re-evaluated");
  c_run: cover property (@(posedge ref_clk) $fell(busy));
  c_pop: cover property (@(posedge ref_clk) fifo_pop);
  c_alert: cover property (@(posedge ref_clk) $rose(alert));
endmodule : smrc_core

// file: verif/smrc_host_model.sv
// Host-side reader that pulls words out of the readout core's buffer.
// Assumes the core pops one word after every second finished byte.
module smrc_host_model
  import smrc_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Core side
  input wire logic [15:0] read_word,
  output smrc_rd_s host_rd,
  // Bench side
  output logic got,
  output logic [15:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    host_rd = '0;
    got = 1'b0;
    word = 16'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One read frame of n words; each word goes out as two bytes
  task automatic read_words(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge ref_clk);
      host_rd.frame = 1'b1;
      word = read_word;
      got = 1'b1;
      host_rd.byte_done = 1'b1;
      @(negedge ref_clk);
      got = 1'b0;
      host_rd.byte_done = 1'b0;
      @(negedge ref_clk);
      host_rd.byte_done = 1'b1;
      @(negedge ref_clk);
      host_rd.byte_done = 1'b0;
      // Head moves, then read_word follows one edge later
      repeat (2) @(negedge ref_clk);
    end
    // After the last word the frame is closed
    host_rd.frame = 1'b0;
  endtask : read_words
endmodule : smrc_host_model

// file: verif/tb_sensor_monitor_readout_core.sv
// Self-checking bench for the sensor monitor readout core.
// Assumes the core, its FIFO and smrc_host_model are compiled first.
module tb_sensor_monitor_readout_core
  import smrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Design inputs, all set at time zero
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic osc_lp_tick = 1'b0;
  logic osc_hs_tick = 1'b0;
  logic oscillator_choice = 1'b0;
  logic [7:0] clocks_per_conversion = 8'h03;
  logic [2:0] addr_strap = 3'h6;
  logic addr_reprogram = 1'b0;
  logic [1:0] op_mode = 2'h1;
  logic [1:0] scan_channel_enables = 2'h3;
  logic scan_launch_bit = 1'b0;
  logic scan_abort_bit = 1'b0;
  logic [1:0] fifo_fill_mode = 2'h1;
  logic [1:0] out_format = 2'h0;
  logic sample_valid = 1'b0;
  smrc_sample_s sample = '0;
  smrc_window_s window_ch0 = '{12'h000, 12'hfff, 12'h000};
  smrc_window_s window_ch1 = '{12'h000, 12'hfff, 12'h000};
  logic [3:0] alert_debounce_limit = 4'h2;
  logic [1:0] flag_high_clear = 2'h0;
  logic [1:0] flag_low_clear = 2'h0;
  smrc_rd_s host_rd;
  // Design outputs
  logic convert_start, convert_ch, busy, alert;
  logic [6:0] slave_addr;
  logic [15:0] read_word, acc_ch0, acc_ch1;
  logic [4:0] fifo_fill, acc_count;
  logic [1:0] flag_high, flag_low;
  // Bench state
  logic got, c0;
  logic [15:0] word, w, sum;
  logic [15:0] rs = 16'hdeda;
  logic [15:0] exp_q[$];
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int t0;
  localparam int LIMIT = 20000;
  ////////////////////////////////////////////////////////////////////////////
  always #2 ref_clk = ~ref_clk;
  smrc_core u_dut (
    .ref_clk, .resetn, .osc_lp_tick, .osc_hs_tick, .oscillator_choice,
    .clocks_per_conversion, .addr_strap, .addr_reprogram, .op_mode,
    .scan_channel_enables, .scan_launch_bit, .scan_abort_bit,
    .fifo_fill_mode, .out_format, .sample_valid, .sample, .window_ch0,
    .window_ch1, .alert_debounce_limit, .flag_high_clear, .flag_low_clear,
    .host_rd, .convert_start, .convert_ch, .slave_addr, .busy, .read_word,
    .fifo_fill, .acc_ch0, .acc_ch1, .acc_count, .flag_high, .flag_low,
    .alert
  );
  smrc_host_model u_host (.ref_clk, .read_word, .host_rd, .got, .word);
  // Fast oscillator ticks every 2nd cycle, slow one every 5th
  always @(negedge ref_clk)
  begin
    osc_hs_tick <= (cyc % 2 == 0);
    osc_lp_tick <= (cyc % 5 == 0);
  end
  // Cycle count; a hang ends in the verdict
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      error_cnt++;
      $display("unexpected run length: expected %0d cycles max", LIMIT);
      give_verdict();
    end
  end
  // Each word the host takes is matched to the oldest note
  always @(posedge ref_clk)
  begin
    if (got === 1'b1 && exp_q.size() > 0)
      check("read_word", exp_q.pop_front(), word);
    else if (got === 1'b1)
      check("surplus read_word", 16'h0, 16'hffff);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string s, input logic [15:0] e, x);
    checks++;
    if (x !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", s, e, x);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : step
  function automatic logic [15:0] rnd();
    rs ^= rs << 7;
    rs ^= rs >> 9;
    rs ^= rs << 8;
    return rs;
  endfunction : rnd
  task automatic launch();
    @(negedge ref_clk);
    scan_launch_bit = 1'b1;
    @(negedge ref_clk);
    scan_launch_bit = 1'b0;
  endtask : launch
  task automatic abort();
    @(negedge ref_clk);
    scan_abort_bit = 1'b1;
    @(negedge ref_clk);
    scan_abort_bit = 1'b0;
  endtask : abort
  task automatic feed(input logic ch, input logic [11:0] c);
    @(negedge ref_clk);
    sample_valid = 1'b1;
    sample = {ch, c};
    @(negedge ref_clk);
    sample_valid = 1'b0;
  endtask : feed
  // Bounded wait for the next conversion strobe
  task automatic wait_conv();
    for (int i = 0; i < 40 && convert_start !== 1'b1; i++)
      @(negedge ref_clk);
  endtask : wait_conv
  // Spacing of consecutive conversions, alternating channels with both enabled
  task automatic pace(input logic sel, input int per);
    oscillator_choice = sel;
    launch();
    wait_conv();
    t0 = cyc;
    c0 = convert_ch;
    step(1);
    wait_conv();
    check("conversion spacing", 16'(per), 16'(cyc - t0));
    check("convert_ch", {15'h0, ~c0}, 16'(convert_ch));
    abort();
    step(1);
    check("busy after abort", 16'h0, 16'(busy));
  endtask : pace
  function automatic logic [15:0] fmt(input logic [1:0] f, logic ch,
                                      logic [11:0] c);
    if (f == 2'h1)
      return {c, 3'h0, ch};
    if (f == 2'h2)
      return {c, 2'h0, ch, 1'b1};
    return {c, 4'h0};
  endfunction : fmt
  // Fill the buffer with n samples, then read back when asked
  task automatic session(input logic [1:0] om, fm, ff, input int n, bit rd);
    logic [15:0] keep[$];
    op_mode = om;
    fifo_fill_mode = fm;
    out_format = ff;
    launch();
    step(2);
    check("busy", 16'h1, 16'(busy));
    for (int i = 0; i < n; i++)
    begin
      w = rnd();
      feed(i[0], w[11:0]);
      // Post-alert filling waits for an alert that never comes here
      if (i < 16 && fm != 2'h3)
        keep.push_back(fmt(ff, i[0], w[11:0]));
      if (i == 2 && rd)
      begin
        exp_q.push_back(16'h0);
        u_host.read_words(1);
      end
    end
    if (n != 16)
      abort();
    step(3);
    check("busy", 16'h0, 16'(busy));
    check("fifo_fill", 16'(keep.size()), 16'(fifo_fill));
    if (rd)
    begin
      foreach (keep[i])
        exp_q.push_back(keep[i]);
      exp_q.push_back(16'h0);
      u_host.read_words(keep.size() + 1);
    end
  endtask : session
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    step(10);
    resetn = 1'b1;
    step(3);
    check("slave_addr", 16'h1a, 16'(slave_addr));
    pace(1'b0, 6);
    pace(1'b1, 15);
    for (int s = 0; s < 8; s++)
    begin
      addr_strap = 3'(s);
      addr_reprogram = 1'b1;
      step(1);
      addr_reprogram = 1'b0;
      step(3);
      w = s[2] ? 16'h18 + 16'(s[1:0]) : 16'h1f - 16'(s[1:0]);
      check("slave_addr", w, 16'(slave_addr));
    end
    addr_strap = 3'h0;
    step(3);
    check("slave_addr held", 16'h1b, 16'(slave_addr));
    session(2'h1, 2'h0, 2'h2, 16, 1'b1);
    session(2'h2, 2'h1, 2'h1, 18, 1'b0);
    // Buffer still holds 16 words here, so the launch must empty it
    launch();
    step(2);
    check("fifo_fill after launch", 16'h0, 16'(fifo_fill));
    feed(1'b0, 12'h123);
    abort();
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    step(3);
    check("fifo_fill after reset", 16'h0, 16'(fifo_fill));
    session(2'h2, 2'h3, 2'h1, 3, 1'b0);
    session(2'h1, 2'h2, 2'h0, 5, 1'b1);
    op_mode = 2'h3;
    scan_channel_enables = 2'h1;
    sum = 16'h0;
    launch();
    step(2);
    for (int i = 0; i < 16; i++)
    begin
      w = rnd();
      sum += {4'h0, w[11:0]};
      feed(1'b0, w[11:0]);
      if (i == 4)
        check("acc_count", 16'h5, 16'(acc_count));
    end
    step(3);
    check("acc_ch0", sum, acc_ch0);
    check("acc_ch1", 16'h0, acc_ch1);
    check("acc_count", 16'h10, 16'(acc_count));
    launch();
    step(2);
    check("acc_ch0 cleared", 16'h0, acc_ch0);
    abort();
    // A miss restarts the count; a dip inside hysteresis does not
    window_ch1 = '{12'h000, 12'h800, 12'h040};
    window_ch0 = '{12'h100, 12'hfff, 12'h000};
    feed(1'b1, 12'h900);
    feed(1'b1, 12'h900);
    feed(1'b1, 12'h100);
    feed(1'b1, 12'h900);
    feed(1'b1, 12'h7f0);
    step(2);
    check("flag_high", 16'h0, 16'(flag_high));
    feed(1'b1, 12'h900);
    step(2);
    check("flag_high", 16'h2, 16'(flag_high));
    check("alert", 16'h1, 16'(alert));
    for (int i = 0; i < 3; i++)
      feed(1'b0, 12'h010);
    step(2);
    check("flag_low", 16'h1, 16'(flag_low));
    flag_high_clear = 2'h2;
    flag_low_clear = 2'h1;
    step(1);
    flag_high_clear = 2'h0;
    flag_low_clear = 2'h0;
    step(2);
    check("flags cleared", 16'h0, 16'({flag_high, flag_low}));
    check("alert", 16'h0, 16'(alert));
    step(10);
    check("pending reads", 16'h0, 16'(exp_q.size()));
    give_verdict();
  end
endmodule : tb_sensor_monitor_readout_core
